// ===== inc/eip_regs.vh
/*
 * register map, field positions and reset values of the external interrupt pin unit.
 * assumes an aligned 32-bit word per register on an axi4-lite slave.
 */
`ifndef EIP_REGS_VH
`define EIP_REGS_VH

// byte offsets
`define EIP_STATUS_CONTROL_OFFSET 12'h000
`define EIP_BREAK_CONTROL_OFFSET  12'h004
`define EIP_CPU_CONTROL_OFFSET    12'h008
// status/control field positions
`define EIP_MODE_BIT    0
`define EIP_MASK_BIT    1
`define EIP_ACK_BIT     2
`define EIP_PENDING_BIT 3
`define EIP_PIN_BIT     4
// break control field positions
`define EIP_BREAK_CLEAR_ALLOW_BIT 0
`define EIP_BREAK_STATE_BIT       1
// cpu control field positions
`define EIP_CPU_GLOBAL_MASK_BIT 0
// vector locations
`define EIP_VECTOR_HIGH 16'hfffa
`define EIP_VECTOR_LOW  16'hfffb
// reset values
`define EIP_STATUS_CONTROL_RESET 8'h00
`define EIP_BREAK_CONTROL_RESET  8'h00
`define EIP_CPU_CONTROL_RESET    8'h00
// axi responses
`define EIP_RESP_OKAY   2'b00
`define EIP_RESP_SLVERR 2'b10

`endif

// ===== verilog/eip_pin_sync.v
/*
 * two-flop synchroniser plus falling-edge detector for the interrupt pin.
 * assumes the pin is asynchronous to clk; pin idles high, so reset loads ones.
 */
`timescale 1ns/1ps
`default_nettype none

module eip_pin_sync (
   input  wire clk,
   input  wire reset_n,
   input  wire pin_n,
   output reg  pin_level,
   output wire fall_edge
);

   reg       meta;
   reg       sync;
   reg [1:0] warm;

   // first flop feeds only the second; pin_level holds the previous sample
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta      <= 1'b1;
         sync      <= 1'b1;
         pin_level <= 1'b1;
      end else begin
         meta      <= pin_n;
         sync      <= meta;
         pin_level <= sync;
      end
   end

   // counts three edges after reset; until then pin_level may still hold its reset one while sync already follows the pin,
   // so a pin held low through reset would look like a falling edge.
   // limitation: a real edge inside those three cycles is not latched
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         warm <= 2'b00;
      else if (warm != 2'b11)
         warm <= warm + 2'b01;
   end

   assign fall_edge = pin_level & ~sync & (warm == 2'b11);

endmodule // eip_pin_sync

`default_nettype wire

// ===== verilog/eip_unit.v
/*
 * external interrupt pin unit: request latch, edge/level select, mask,
 * acknowledge, break-state qualifier and an axi4-lite register slave.
 * assumes the cpu reports vector fetches and break state as same-clock pulses/levels.
 * assumes the pin is asynchronous and may be held low through reset; the leaf
 * synchroniser hides the reset-to-idle step so that no false edge is latched.
 * assumes one write and one read at most under way on the register bus,
 * with byte lane 0 carrying every 8-bit register.
 */
`timescale 1ns/1ps
`default_nettype none
`include "eip_regs.vh"

// Contract
// - falling pin edge sets the request latch
// - latch cleared by vector fetch, software acknowledge, or reset
// - level mode: triggers on low levels; clear needs acknowledge and pin high
// - writing one to acknowledge bit clears latch; bit reads zero
// - a falling edge after acknowledge sets the latch again
// - unmasked taken request fetches vector from fffa and fffb
// - level mode: acknowledge and pin release in any order; low keeps pending
// - reset clears latch and sensitivity select even with pin low
// - edge mode: vector fetch or acknowledge clears latch at once
// - pending flag reads latch state regardless of mask
// - pin level readable for branch-on-pin-level instructions
// - clear-allow set: software clears in break state, stays cleared
// - clear-allow clear: acknowledge writes during break do nothing
// - mask bit one disables requests, zero enables; reset clears it
// - select bit zero edge only, one edge plus level; reset clears
// - request reaches priority logic only unmasked and not globally masked
module eip_unit (
   input  wire        clk,
   input  wire        reset_n,
   input  wire        ext_int_pin_n,
   input  wire        vector_fetch,
   input  wire        break_state,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg         cpu_irq_request,
   output reg  [15:0] vector_address,
   output reg         pin_level
);

   wire        pin_sync;
   wire        fall_edge;
   reg         latch;
   reg         ack_pending;
   reg         level_mode;
   reg         request_mask_bit;
   reg         break_clear_allow;
   reg         cpu_global_mask;
   reg         aw_held;
   reg         w_held;
   reg  [11:0] aw_addr;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   wire        wr_fire;
   wire        ack_write;
   wire        sw_clear_ok;
   wire        ack_event;
   reg         next_latch;
   reg         next_ack_pending;
   wire [2:0]  wr_sel;
   wire [2:0]  rd_sel;

   // one-hot register selects; none means the offset is unmapped
   localparam [2:0] SEL_NONE   = 3'b000;
   localparam [2:0] SEL_STATUS = 3'b001;
   localparam [2:0] SEL_BREAK  = 3'b010;
   localparam [2:0] SEL_CPU    = 3'b100;

   // shared by the write and the read path so both agree on the map
   function [2:0] decode_offset;
      input [11:0] addr;
      begin
         case (addr)
            `EIP_STATUS_CONTROL_OFFSET: decode_offset = SEL_STATUS;
            `EIP_BREAK_CONTROL_OFFSET:  decode_offset = SEL_BREAK;
            `EIP_CPU_CONTROL_OFFSET:    decode_offset = SEL_CPU;
            default:                    decode_offset = SEL_NONE;
         endcase
      end
   endfunction

   // synchroniser and edge detect live in their own leaf
   // pin synchronised before any logic reads it
   eip_pin_sync u_sync (
      .clk       (clk),
      .reset_n   (reset_n),
      .pin_n     (ext_int_pin_n),
      .pin_level (pin_sync),
      .fall_edge (fall_edge)
   );

   // write commits once both address and data have been taken
   assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
   assign ack_write = wr_fire & (wr_sel == SEL_STATUS) &
                      w_strb[0] & w_data[`EIP_ACK_BIT];
   // held write address decodes once; the read address decodes as it is offered
   assign wr_sel = decode_offset(aw_addr);
   assign rd_sel = decode_offset(s_axi_araddr);
   assign sw_clear_ok = ~break_state | break_clear_allow;
   // vector fetch always acknowledges; write only if allowed
   assign ack_event = vector_fetch | (ack_write & sw_clear_ok);

   // latch next state; set wins over a simultaneous clear
   // break state gates only software clears, never the pin side
   always @* begin
      next_latch       = latch;
      next_ack_pending = ack_pending;
      if (level_mode) begin
         // acknowledge remembered until the pin is released
         if (ack_event)
            next_ack_pending = 1'b1;
         // clear needs acknowledge and pin high
         if ((ack_pending | ack_event) & pin_sync) begin
            next_latch       = 1'b0;
            next_ack_pending = 1'b0;
         end
         if (~pin_sync & ~(ack_pending | ack_event))
            next_latch = 1'b1;
      end else begin
         // edge mode forgets any acknowledge left over from level mode
         next_ack_pending = 1'b0;
         if (ack_event)
            next_latch = 1'b0;
      end
      // falling edge sets the latch; even after acknowledge
      // a new edge also cancels a level-mode acknowledge still waiting for release
      if (fall_edge) begin
         next_latch       = 1'b1;
         next_ack_pending = 1'b0;
      end
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         latch       <= 1'b0;
         ack_pending <= 1'b0;
      end else begin
         latch       <= next_latch;
         ack_pending <= next_ack_pending;
      end
   end

   // request, vector and pin level outputs all registered
   // registering from next_latch gives a glitch-free request line towards the cpu with no cycle of latency behind the latch
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cpu_irq_request <= 1'b0;
         vector_address  <= `EIP_VECTOR_HIGH;
         pin_level       <= 1'b1;
      end else begin
         // local and global masks gate request
         cpu_irq_request <= next_latch & ~request_mask_bit & ~cpu_global_mask;
         vector_address  <= `EIP_VECTOR_HIGH;
         pin_level       <= pin_sync;
      end
   end

   // axi write channel: address and data accepted in either order
   // each half is parked until the other has arrived
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 12'h000;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `EIP_RESP_OKAY;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // unmapped writes are answered with an error and change nothing
            if (wr_sel != SEL_NONE)
               s_axi_bresp <= `EIP_RESP_OKAY;
            else
               s_axi_bresp <= `EIP_RESP_SLVERR;
         end
         // ready again only after the response is taken: one write at a time
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // control bits written by software
   // a write with byte lane 0 off is ignored: every register lives in bits 7:0
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         level_mode        <= 1'b0;
         request_mask_bit  <= 1'b0;
         break_clear_allow <= 1'b0;
         cpu_global_mask   <= 1'b0;
      end else if (wr_fire & w_strb[0]) begin
         if (wr_sel == SEL_STATUS) begin
            // select edge or edge plus level
            level_mode       <= w_data[`EIP_MODE_BIT];
            request_mask_bit <= w_data[`EIP_MASK_BIT];
         end
         if (wr_sel == SEL_BREAK)
            break_clear_allow <= w_data[`EIP_BREAK_CLEAR_ALLOW_BIT];
         // global mask stands in for the cpu's own interrupt mask
         if (wr_sel == SEL_CPU)
            cpu_global_mask <= w_data[`EIP_CPU_GLOBAL_MASK_BIT];
      end
   end

   // axi read channel; data captured when the address is taken
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `EIP_RESP_OKAY;
      end else begin
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            // bits above the register and the ack bit stay zero on every read
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `EIP_RESP_OKAY;
            // unmapped reads return zero data with an error response
            case (rd_sel)
               SEL_STATUS: begin
                  s_axi_rdata[`EIP_MODE_BIT] <= level_mode;
                  s_axi_rdata[`EIP_MASK_BIT] <= request_mask_bit;
                  // acknowledge reads zero; pending ignores mask
                  s_axi_rdata[`EIP_PENDING_BIT] <= latch;
                  s_axi_rdata[`EIP_PIN_BIT]     <= pin_sync;
               end
               SEL_BREAK: begin
                  s_axi_rdata[`EIP_BREAK_CLEAR_ALLOW_BIT] <= break_clear_allow;
                  s_axi_rdata[`EIP_BREAK_STATE_BIT]       <= break_state;
               end
               SEL_CPU: begin
                  s_axi_rdata[`EIP_CPU_GLOBAL_MASK_BIT] <= cpu_global_mask;
               end
               default: begin
                  s_axi_rresp <= `EIP_RESP_SLVERR;
               end
            endcase
         end
         if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // eip_unit

`default_nettype wire

// ===== tb/eip_unit_sva.sv
/*
 * port-level assertions for the external interrupt pin unit.
 * assumes a bind onto eip_unit, one clock domain and the hand-over latencies.
 */
`timescale 1ns/1ps
`default_nettype none
module eip_unit_sva (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        ext_int_pin_n,
   input wire logic        vector_fetch,
   input wire logic [11:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        cpu_irq_request,
   input wire logic [15:0] vector_address,
   input wire logic        pin_level
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // five quiet samples keep any edge still in the synchroniser out of the way
   vec_fixed_a: assert property (vector_address == 16'hfffa) else $error("vector address wrong");
   pin_follow_a: assert property ($stable(ext_int_pin_n)[*5] |-> pin_level == ext_int_pin_n)
      else $error("pin level does not follow pin");
   fetch_clear_a: assert property ($stable(ext_int_pin_n)[*5] ##0 (ext_int_pin_n && vector_fetch)
      |-> ##2 !cpu_irq_request) else $error("vector fetch left request up");
   reset_quiet_a: assert property ($rose(reset_n) |-> !cpu_irq_request [*2])
      else $error("request up after reset");
   ack_reads_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[2])
      else $error("ack or upper bits read nonzero");
   pin_read_a: assert property ($stable(ext_int_pin_n)[*5] ##0 (s_axi_arvalid && s_axi_arready
      && s_axi_araddr == 12'h000) |=> s_axi_rdata[4] == pin_level) else $error("pin bit read wrong");
   r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read answer");
   w_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("late write answer");
endmodule // eip_unit_sva
bind eip_unit eip_unit_sva chk (
   .clk             (clk),
   .reset_n         (reset_n),
   .ext_int_pin_n   (ext_int_pin_n),
   .vector_fetch    (vector_fetch),
   .s_axi_araddr    (s_axi_araddr),
   .s_axi_arvalid   (s_axi_arvalid),
   .s_axi_arready   (s_axi_arready),
   .s_axi_rdata     (s_axi_rdata),
   .s_axi_rvalid    (s_axi_rvalid),
   .s_axi_awvalid   (s_axi_awvalid),
   .s_axi_awready   (s_axi_awready),
   .s_axi_wvalid    (s_axi_wvalid),
   .s_axi_wready    (s_axi_wready),
   .s_axi_bvalid    (s_axi_bvalid),
   .cpu_irq_request (cpu_irq_request),
   .vector_address  (vector_address),
   .pin_level       (pin_level)
);
`default_nettype wire

// ===== tb/eip_irq_source.sv
/*
 * model of the external source on the active-low interrupt pin.
 * assumes its task is called from the bench in the unit's clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module eip_irq_source (
   input  wire logic clk,
   output var  logic pin_n
);
   // the pin idles high behind its pull-up
   initial pin_n = 1'h1;
   // level changes land just after an edge, never on it
   task automatic drive(input logic lvl);
      @(posedge clk);
      pin_n <= lvl;
   endtask
endmodule // eip_irq_source
`default_nettype wire

// ===== tb/external_interrupt_pin_unit_bench.sv
/*
 * self-checking bench of the external interrupt pin unit.
 * assumes eip_unit, the pin source model and the bound checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module external_interrupt_pin_unit_bench;
   logic        clk = 1'h0, reset_n = 1'h0, vector_fetch = 1'h0, break_state = 1'h0, pin_n;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, cpu_irq_request, pin_level;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rrv;
   logic [15:0] vector_address;
   logic [3:0]  s_axi_wstrb = 4'hf;
   int          n_mismatch = 0, n_tests = 0, cyc = 0;
   eip_irq_source src (.clk, .pin_n);
   eip_unit uut (.clk, .reset_n, .ext_int_pin_n(pin_n), .vector_fetch, .break_state, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_irq_request, .vector_address,
      .pin_level);
   // 4 ns clock
   always #2 clk = ~clk;
   // a hung handshake must still end in the verdict
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_mismatch++;
         close_out();
      end
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // each channel is dropped at the edge that takes it; bready stays up until bvalid
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      rdv = s_axi_rdata;
      rrv = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   task automatic st(input logic [7:0] e);
      rd(12'h000);
      check("status", rdv, {24'h0, e});
   endtask
   task automatic fetch;
      @(posedge clk);
      vector_fetch <= 1'h1;
      @(posedge clk);
      vector_fetch <= 1'h0;
   endtask
   // reset values, unmapped slot and vector location
   task automatic t_reset;
      st(8'h10);
      rd(12'h004);
      check("break ctrl", rdv, 32'h0);
      rd(12'h008);
      check("cpu ctrl", rdv, 32'h0);
      rd(12'h00c);
      check("unmapped", {rdv[29:0], rrv}, 32'h2);
      check("vector", vector_address, 16'hfffa);
   endtask
   // edge mode: latch, fetch clear, ack clear, re-arm after ack
   task automatic t_edge;
      src.drive(1'h0);
      idle(6);
      st(8'h08);
      check("irq", cpu_irq_request, 1'h1);
      src.drive(1'h1);
      idle(6);
      st(8'h18);
      fetch();
      idle(3);
      st(8'h10);
      check("irq", cpu_irq_request, 1'h0);
      src.drive(1'h0);
      idle(6);
      wr(12'h000, 8'h04);
      st(8'h00);
      src.drive(1'h1);
      idle(4);
      src.drive(1'h0);
      idle(6);
      st(8'h08);
      wr(12'h000, 8'h04);
      src.drive(1'h1);
   endtask
   // local mask, global mask, and polling under mask
   task automatic t_mask;
      wr(12'h000, 8'h02);
      src.drive(1'h0);
      idle(6);
      check("irq", cpu_irq_request, 1'h0);
      st(8'h0a);
      wr(12'h008, 8'h01);
      wr(12'h000, 8'h00);
      idle(2);
      check("irq", cpu_irq_request, 1'h0);
      wr(12'h008, 8'h00);
      idle(2);
      check("irq", cpu_irq_request, 1'h1);
      s_axi_wstrb <= 4'h0;
      wr(12'h000, 8'h04);
      s_axi_wstrb <= 4'hf;
      st(8'h08);
      wr(12'h000, 8'h04);
      src.drive(1'h1);
      idle(4);
   endtask
   // level mode in both orders, then reset with the pin low
   task automatic t_level;
      wr(12'h000, 8'h01);
      src.drive(1'h0);
      idle(6);
      wr(12'h000, 8'h03);
      idle(2);
      check("irq", cpu_irq_request, 1'h0);
      wr(12'h000, 8'h05);
      idle(3);
      st(8'h09);
      src.drive(1'h1);
      idle(6);
      st(8'h11);
      src.drive(1'h0);
      idle(6);
      src.drive(1'h1);
      idle(6);
      st(8'h19);
      wr(12'h000, 8'h05);
      st(8'h11);
      src.drive(1'h0);
      idle(6);
      reset_n <= 1'h0;
      idle(2);
      check("irq in reset", cpu_irq_request, 1'h0);
      reset_n <= 1'h1;
      idle(6);
      st(8'h00);
      check("irq after reset", cpu_irq_request, 1'h0);
      src.drive(1'h1);
      idle(6);
      st(8'h10);
   endtask
   // break state blocks acks unless clearing is allowed
   task automatic t_break;
      break_state <= 1'h1;
      src.drive(1'h0);
      idle(6);
      wr(12'h000, 8'h04);
      st(8'h08);
      wr(12'h004, 8'h01);
      wr(12'h000, 8'h04);
      st(8'h00);
      rd(12'h004);
      check("break ctrl", rdv, 32'h3);
      break_state <= 1'h0;
      idle(2);
      st(8'h00);
      src.drive(1'h1);
   endtask
   initial begin
      idle(12);
      reset_n <= 1'h1;
      t_reset();
      t_edge();
      t_mask();
      t_level();
      t_break();
      close_out();
   end
endmodule // external_interrupt_pin_unit_bench
`default_nettype wire
